// >>> rtl/tsp_pkg.sv
// Purpose: constants, types and register map of the tdm-8 serial port
// Assumes: apb slave on pclk, 32-bit word per register
// Notes: status word layout is given by tsp_stat_s
package tsp_pkg;

  // ----------------------------------------------------------------
  // stream geometry
  // ----------------------------------------------------------------
  localparam int SLOTS = 8;
  localparam int SLOT_BITS = 32;
  localparam int EVT_WORDS = 4;
  localparam int CNT_W = 6;
  localparam logic [5:0] CNT_ZERO = 6'h00;
  localparam logic [5:0] CNT_ONE = 6'h01;
  localparam logic [5:0] CNT_FULL = 6'h20;
  localparam logic [2:0] SLOT_ZERO = 3'h0;
  localparam logic [2:0] SLOT_ONE = 3'h1;
  localparam logic [2:0] SLOT_LAST = 3'h7;
  localparam logic [1:0] WCNT_ZERO = 2'h0;
  localparam logic [1:0] WCNT_ONE = 2'h1;
  localparam logic [1:0] WCNT_LAST = 2'h3;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_TRIG = 8'h00;
  localparam logic [7:0] OFF_POL = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_RXD = 8'h0c;
  localparam logic [7:0] OFF_TXD = 8'h10;
  localparam int TRIG_W = 8;
  localparam logic [7:0] TRIG_RESET = 8'h00;
  localparam int TRIG_RST = 0;
  localparam int TRIG_RXEN = 3;
  localparam int TRIG_TXEN = 4;
  localparam int POL_W = 2;
  localparam logic [1:0] POL_RESET = 2'h0;
  localparam int POL_BCLK = 0;
  localparam int POL_FS = 1;
  localparam int ST_OVR = 17;
  localparam int ST_UND = 19;
  localparam int ST_EVT = 20;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RX_IDLE, RX_ARMED, RX_RUN} tsp_rx_e;

  typedef struct packed {
    logic bclk;
    logic fsync;
    logic data;
  } tsp_pins_s;

  typedef struct packed {
    logic [10:0] zero;
    logic evt;
    logic und;
    logic txe;
    logic ovr;
    logic valid;
    logic [2:0] rsv;
    logic [1:0] wcnt;
    logic [2:0] slot;
    logic [5:0] bits;
    logic [1:0] state;
  } tsp_stat_s;

endpackage : tsp_pkg

// >>> rtl/tsp_sync.sv
// Purpose: two-flop synchroniser with edge detect
// Assumes: d is asynchronous to pclk
// Notes: first flop feeds only the second
`timescale 1ns/1ps
module tsp_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q,
  output logic rise,
  output logic fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // ----------------------------------------------------------------
  // synchroniser and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign q = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule : tsp_sync

// >>> rtl/tsp_port.sv
// Purpose: tdm-8 audio serial port, receive and transmit, apb registers
// Assumes: far end drives bit clock and frame sync; pclk 200 mhz
// Notes: bclk_out is the only output not taken from a flip-flop
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module tsp_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tsp_pkg::tsp_pins_s stream_in,
  output logic bclk_out,
  output logic frame_sync_out,
  output logic serial_data_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] trigger_bits_reg;
  logic [1:0] pol_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  tsp_pkg::tsp_rx_e rx_state_r;
  tsp_pkg::tsp_rx_e rx_state_nxt;
  logic [5:0] bit_cnt_r;
  logic [5:0] bit_cnt_nxt;
  logic [2:0] slot_r;
  logic [1:0] wcnt_r;
  logic [31:0] rx_sh_r;
  logic [31:0] rx_data_r;
  logic rx_valid_r;
  logic ovr_r;
  logic evt_r;
  logic fs_seen_r;
  logic tx_act_r;
  logic [5:0] tx_cnt_r;
  logic [2:0] tx_slot_r;
  logic [31:0] tx_sh_r;
  logic [31:0] tx_hold_r;
  logic tx_empty_r;
  logic und_r;
  logic fs_out_r;
  logic data_out_r;

  // ----------------------------------------------------------------
  // pin conditioning and synchronisers
  // ----------------------------------------------------------------
  logic bclk_pin_int;
  logic fs_pin_int;
  logic bclk_s;
  logic bclk_fall;
  logic bclk_rise;
  logic fs_s;
  logic data_s;

  assign bclk_pin_int = ~stream_in.bclk ^ pol_r[tsp_pkg::POL_BCLK];
  assign fs_pin_int = stream_in.fsync ^ pol_r[tsp_pkg::POL_FS];
  assign bclk_out = stream_in.bclk;

  tsp_sync u_sync_bclk (
    .pclk(pclk),
    .presetn(presetn),
    .d(bclk_pin_int),
    .q(bclk_s),
    .rise(bclk_rise),
    .fall(bclk_fall)
  );

  tsp_sync u_sync_fs (
    .pclk(pclk),
    .presetn(presetn),
    .d(fs_pin_int),
    .q(fs_s),
    .rise(),
    .fall()
  );

  tsp_sync u_sync_data (
    .pclk(pclk),
    .presetn(presetn),
    .d(stream_in.data),
    .q(data_s),
    .rise(),
    .fall()
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup_acc;
  logic acc;
  logic wr;
  logic rd;
  logic hit_trig;
  logic hit_pol;
  logic hit_stat;
  logic hit_rxd;
  logic hit_txd;
  logic addr_hit;
  logic rx_pop;
  logic tx_fill;
  logic stat_w1c;
  logic tile_rst;
  logic rx_en;
  logic tx_en;
  tsp_pkg::tsp_stat_s stat_w;
  logic [31:0] rd_mux;

  assign setup_acc = psel & penable & ~pready_r;
  assign acc = psel & penable & pready_r;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign hit_trig = paddr == tsp_pkg::OFF_TRIG;
  assign hit_pol = paddr == tsp_pkg::OFF_POL;
  assign hit_stat = paddr == tsp_pkg::OFF_STAT;
  assign hit_rxd = paddr == tsp_pkg::OFF_RXD;
  assign hit_txd = paddr == tsp_pkg::OFF_TXD;
  assign addr_hit = hit_trig | hit_pol | hit_stat | hit_rxd | hit_txd;
  assign rx_pop = rd & hit_rxd;
  assign tx_fill = wr & hit_txd;
  assign stat_w1c = wr & hit_stat;
  assign tile_rst = trigger_bits_reg[tsp_pkg::TRIG_RST];
  assign rx_en = trigger_bits_reg[tsp_pkg::TRIG_RXEN];
  assign tx_en = trigger_bits_reg[tsp_pkg::TRIG_TXEN];

  assign stat_w = '{zero: 11'h000, evt: evt_r, und: und_r,
    txe: tx_empty_r, ovr: ovr_r, valid: rx_valid_r, rsv: 3'h0,
    wcnt: wcnt_r, slot: slot_r, bits: bit_cnt_r, state: rx_state_r};

  assign rd_mux = hit_trig ? {24'h000000, trigger_bits_reg} :
    hit_pol ? {30'h0, pol_r} :
    hit_stat ? stat_w :
    hit_rxd ? rx_data_r : tsp_pkg::WORD_ZERO;

  // ----------------------------------------------------------------
  // apb slave: one wait state, registered answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= tsp_pkg::WORD_ZERO;
    end else begin
      pready_r <= setup_acc;
      pslverr_r <= setup_acc & ~addr_hit;
      prdata_r <= (setup_acc & ~pwrite) ? rd_mux : tsp_pkg::WORD_ZERO;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_bits_reg <= tsp_pkg::TRIG_RESET;
      pol_r <= tsp_pkg::POL_RESET;
    end else begin
      if (wr && hit_trig) begin
        trigger_bits_reg <= pwdata[7:0];
      end
      if (wr && hit_pol) begin
        pol_r <= pwdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // bit, slot and word counters
  // ----------------------------------------------------------------
  logic fs_hit;
  logic [5:0] cnt_inc;
  logic word_end;
  logic frame_end;
  logic rx_cap;
  logic [31:0] rx_sh_nxt;

  assign fs_hit = bclk_fall & fs_s;
  assign cnt_inc = fs_s ? tsp_pkg::CNT_ONE : bit_cnt_r + tsp_pkg::CNT_ONE;
  assign word_end = bclk_fall & (cnt_inc == tsp_pkg::CNT_FULL);
  assign bit_cnt_nxt = word_end ? tsp_pkg::CNT_ZERO : cnt_inc;
  assign frame_end = word_end & (slot_r == tsp_pkg::SLOT_LAST);
  assign rx_cap = bclk_fall & ((rx_state_r == tsp_pkg::RX_RUN) |
    ((rx_state_r == tsp_pkg::RX_ARMED) & fs_s));
  assign rx_sh_nxt = {rx_sh_r[30:0], data_s};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_r <= tsp_pkg::CNT_ZERO;
      slot_r <= tsp_pkg::SLOT_ZERO;
      wcnt_r <= tsp_pkg::WCNT_ZERO;
    end else if (tile_rst) begin
      bit_cnt_r <= tsp_pkg::CNT_ZERO;
      slot_r <= tsp_pkg::SLOT_ZERO;
      wcnt_r <= tsp_pkg::WCNT_ZERO;
    end else if (bclk_fall) begin
      bit_cnt_r <= bit_cnt_nxt;
      if (fs_hit) begin
        slot_r <= tsp_pkg::SLOT_ZERO;
        wcnt_r <= tsp_pkg::WCNT_ZERO;
      end else if (word_end) begin
        slot_r <= slot_r + tsp_pkg::SLOT_ONE;
        wcnt_r <= wcnt_r + tsp_pkg::WCNT_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver state machine
  // ----------------------------------------------------------------
  always_comb begin
    rx_state_nxt = rx_state_r;
    case (rx_state_r)
      tsp_pkg::RX_IDLE: begin
        if (rx_en) begin
          rx_state_nxt = tsp_pkg::RX_ARMED;
        end
      end
      tsp_pkg::RX_ARMED: begin
        if (!rx_en) begin
          rx_state_nxt = tsp_pkg::RX_IDLE;
        end else if (fs_hit) begin
          rx_state_nxt = tsp_pkg::RX_RUN;
        end
      end
      tsp_pkg::RX_RUN: begin
        if (frame_end) begin
          rx_state_nxt = rx_en ? tsp_pkg::RX_ARMED : tsp_pkg::RX_IDLE;
        end
      end
      default: begin
        rx_state_nxt = tsp_pkg::RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_r <= tsp_pkg::RX_IDLE;
      rx_sh_r <= tsp_pkg::WORD_ZERO;
    end else if (tile_rst) begin
      rx_state_r <= tsp_pkg::RX_IDLE;
      rx_sh_r <= tsp_pkg::WORD_ZERO;
    end else begin
      rx_state_r <= rx_state_nxt;
      if (rx_cap) begin
        rx_sh_r <= rx_sh_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive holding word and status flags; set wins over clear
  // ----------------------------------------------------------------
  logic rx_word;
  logic evt_set;
  logic tx_und;

  assign rx_word = rx_cap & word_end;
  assign evt_set = word_end & (wcnt_r == tsp_pkg::WCNT_LAST) & ~fs_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_r <= tsp_pkg::WORD_ZERO;
      rx_valid_r <= 1'b0;
      ovr_r <= 1'b0;
      evt_r <= 1'b0;
      und_r <= 1'b0;
    end else begin
      if (rx_word) begin
        rx_data_r <= rx_sh_nxt;
      end
      rx_valid_r <= rx_word | (rx_valid_r & ~rx_pop);
      ovr_r <= (rx_word & rx_valid_r & ~rx_pop) |
        (ovr_r & ~(stat_w1c & pwdata[tsp_pkg::ST_OVR]));
      evt_r <= evt_set | (evt_r & ~(stat_w1c & pwdata[tsp_pkg::ST_EVT]));
      und_r <= tx_und |
        (und_r & ~(stat_w1c & pwdata[tsp_pkg::ST_UND]));
    end
  end

  // ----------------------------------------------------------------
  // transmitter: shift and latch on the internal rising edge
  // ----------------------------------------------------------------
  logic tx_start;
  logic tx_next;
  logic tx_stop;
  logic tx_shift;
  logic tx_load;
  logic [31:0] tx_word;

  assign tx_start = bclk_rise & fs_seen_r & tx_en;
  assign tx_next = bclk_rise & tx_act_r & (tx_cnt_r == tsp_pkg::CNT_FULL) &
    (tx_slot_r != tsp_pkg::SLOT_LAST);
  assign tx_stop = bclk_rise & tx_act_r & (tx_cnt_r == tsp_pkg::CNT_FULL) &
    (tx_slot_r == tsp_pkg::SLOT_LAST) & ~tx_start;
  assign tx_load = tx_start | tx_next;
  assign tx_shift = bclk_rise & tx_act_r & ~tx_load & ~tx_stop;
  assign tx_und = tx_load & tx_empty_r;
  assign tx_word = tx_empty_r ? tsp_pkg::WORD_ZERO : tx_hold_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold_r <= tsp_pkg::WORD_ZERO;
      tx_empty_r <= 1'b1;
    end else begin
      if (tx_fill) begin
        tx_hold_r <= pwdata;
      end
      tx_empty_r <= ~tx_fill & (tx_load | tx_empty_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_seen_r <= 1'b0;
      tx_act_r <= 1'b0;
      tx_cnt_r <= tsp_pkg::CNT_ZERO;
      tx_slot_r <= tsp_pkg::SLOT_ZERO;
      tx_sh_r <= tsp_pkg::WORD_ZERO;
      fs_out_r <= 1'b0;
      data_out_r <= 1'b0;
    end else if (tile_rst) begin
      fs_seen_r <= 1'b0;
      tx_act_r <= 1'b0;
      tx_cnt_r <= tsp_pkg::CNT_ZERO;
      tx_slot_r <= tsp_pkg::SLOT_ZERO;
      tx_sh_r <= tsp_pkg::WORD_ZERO;
      fs_out_r <= 1'b0;
      data_out_r <= 1'b0;
    end else begin
      if (fs_hit) begin
        fs_seen_r <= 1'b1;
      end else if (bclk_rise) begin
        fs_seen_r <= 1'b0;
      end
      if (bclk_rise) begin
        fs_out_r <= tx_start;
      end
      if (tx_load) begin
        tx_act_r <= 1'b1;
        tx_cnt_r <= tsp_pkg::CNT_ONE;
        tx_slot_r <= tx_start ? tsp_pkg::SLOT_ZERO :
          tx_slot_r + tsp_pkg::SLOT_ONE;
        data_out_r <= tx_word[31];
        tx_sh_r <= {tx_word[30:0], 1'b0};
      end else if (tx_stop) begin
        tx_act_r <= 1'b0;
        data_out_r <= 1'b0;
      end else if (tx_shift) begin
        tx_cnt_r <= tx_cnt_r + tsp_pkg::CNT_ONE;
        data_out_r <= tx_sh_r[31];
        tx_sh_r <= {tx_sh_r[30:0], 1'b0};
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign frame_sync_out = fs_out_r;
  assign serial_data_out = data_out_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_bit_range;
    @(posedge pclk) disable iff (!presetn)
      bit_cnt_r < tsp_pkg::CNT_FULL;
  endproperty
  a_bit_range: assert property (p_bit_range)
    else $error("bit counter out of range");

  property p_fs_restart;
    @(posedge pclk) disable iff (!presetn || tile_rst)
      fs_hit |=> (bit_cnt_r == tsp_pkg::CNT_ONE) &&
        (slot_r == tsp_pkg::SLOT_ZERO);
  endproperty
  a_fs_restart: assert property (p_fs_restart)
    else $error("frame sync did not restart bit count");

  property p_word_wrap;
    @(posedge pclk) disable iff (!presetn || tile_rst)
      bclk_fall && !fs_s &&
        bit_cnt_r == tsp_pkg::CNT_FULL - tsp_pkg::CNT_ONE |=>
        bit_cnt_r == tsp_pkg::CNT_ZERO;
  endproperty
  a_word_wrap: assert property (p_word_wrap)
    else $error("bit counter did not wrap at 32");

  property p_slot_wrap;
    @(posedge pclk) disable iff (!presetn || tile_rst)
      word_end && !fs_hit && slot_r == tsp_pkg::SLOT_LAST |=>
        slot_r == tsp_pkg::SLOT_ZERO;
  endproperty
  a_slot_wrap: assert property (p_slot_wrap)
    else $error("slot count did not wrap after eight");

  property p_evt_four;
    @(posedge pclk) disable iff (!presetn)
      $rose(evt_r) |->
        $past(word_end) && $past(wcnt_r) == tsp_pkg::WCNT_LAST;
  endproperty
  a_evt_four: assert property (p_evt_four)
    else $error("word event not after fourth word");

  property p_rx_gate;
    @(posedge pclk) disable iff (!presetn)
      !rx_en && rx_state_r != tsp_pkg::RX_RUN |=>
        rx_state_r == tsp_pkg::RX_IDLE;
  endproperty
  a_rx_gate: assert property (p_rx_gate)
    else $error("receiver not idle while disabled");

  property p_out_align;
    @(posedge pclk) disable iff (!presetn || tile_rst)
      !$past(bclk_rise) |-> $stable(fs_out_r) && $stable(data_out_r);
  endproperty
  a_out_align: assert property (p_out_align)
    else $error("output latch changed off rising edge");

  property p_fs_out_len;
    @(posedge pclk) disable iff (!presetn || tile_rst)
      fs_out_r && bclk_rise && !tx_start |=> !fs_out_r;
  endproperty
  a_fs_out_len: assert property (p_fs_out_len)
    else $error("frame sync out longer than one bit");

  property p_bclk_pass;
    @(posedge pclk) bclk_out == stream_in.bclk;
  endproperty
  a_bclk_pass: assert property (p_bclk_pass)
    else $error("bit clock not passed through");

  property p_apb_wait;
    @(posedge pclk) disable iff (!presetn)
      setup_acc |=> pready_r ##1 !pready_r;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb answer timing wrong");

  c_rx_word: cover property (@(posedge pclk) disable iff (!presetn)
    rx_word);
  c_evt: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(evt_r));
  c_fs_out: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(fs_out_r));

endmodule : tsp_port

// >>> tb/tsp_audio_dev.sv
// Purpose: far-end audio device, drives bit clock, frame sync and data
// Assumes: 48 ns bit clock, held at its idle level inv[0] between frames
// Notes: captures the outgoing stream on its own rising edges
`timescale 1ns/1ps
module tsp_audio_dev (
  output tsp_pkg::tsp_pins_s pins,
  input wire logic frame_sync_out,
  input wire logic serial_data_out
);
  // ----------------------------------------------------------------
  // frame generator
  // ----------------------------------------------------------------
  localparam realtime HALF = 24.0;
  logic [31:0] tx_word [0:7];
  logic [31:0] sh_r;
  int fs_seen;
  int tx_bits;

  initial begin
    pins = tsp_pkg::tsp_pins_s'(3'h0);
    fs_seen = 0;
    tx_bits = 256;
  end

  // eight slots of 32 bits, msb first, sync with the first bit
  // inv[0] inverts bit clock, inv[1] frame sync, at the pins
  task automatic send_frame(input logic [255:0] w, input logic [1:0] inv);
    int k;
    pins.bclk = inv[0];
    #1.25;
    for (k = 0; k < 256; k++) begin
      pins.fsync = (k == 0) ^ inv[1];
      pins.data = w[255 - k];
      #HALF pins.bclk = ~inv[0];
      #HALF pins.bclk = inv[0];
    end
    pins.fsync = inv[1];
    pins.data = ~pins.data;
  endtask : send_frame

  // ----------------------------------------------------------------
  // outgoing stream capture
  // ----------------------------------------------------------------
  always @(posedge pins.bclk) begin
    if (frame_sync_out === 1'h1) begin
      fs_seen++;
      tx_bits = 0;
    end
    if (tx_bits < 256) begin
      sh_r = {sh_r[30:0], serial_data_out};
      tx_bits++;
      if (tx_bits % 32 == 0) begin
        tx_word[tx_bits / 32 - 1] = sh_r;
      end
    end
  end
endmodule : tsp_audio_dev

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the tdm-8 serial port
// Assumes: apb master on pclk, partner model drives the stream
// Notes: random words from an lfsr with a fixed start
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, st, txw, seed;
  logic pready, pslverr, bclk_out, frame_sync_out, serial_data_out;
  logic [255:0] frame;
  tsp_pkg::tsp_pins_s pins;
  int failures, cmp_count, cyc, i, n, fs0;

  tsp_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stream_in(pins), .bclk_out(bclk_out),
    .frame_sync_out(frame_sync_out), .serial_data_out(serial_data_out));
  tsp_audio_dev dev (.pins(pins), .frame_sync_out(frame_sync_out),
    .serial_data_out(serial_data_out));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return (s >> 1) ^ (s[0] ? 32'h8020_0003 : 32'h0);
  endfunction : lfsr

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // clock, timeout, pass-through watch
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end

  always @(pins.bclk) begin
    #1;
    chk("bclk_out", {31'h0, bclk_out}, {31'h0, pins.bclk});
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    failures = 0;
    cmp_count = 0;
    cyc = 0;
    seed = 32'hefd6_07d7;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, tsp_pkg::OFF_TRIG, 32'h0, rd);
    chk("trig reset", rd, 32'h0);
    apb(1'h0, tsp_pkg::OFF_STAT, 32'h0, rd);
    chk("status reset", rd, 32'h0004_0000);
    apb(1'h0, 8'h14, 32'h0, rd);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    seed = lfsr(seed);
    apb(1'h1, tsp_pkg::OFF_POL, seed, rd);
    apb(1'h0, tsp_pkg::OFF_POL, 32'h0, rd);
    chk("pol", rd, {30'h0, seed[1:0]});
    apb(1'h1, tsp_pkg::OFF_POL, 32'h0, rd);
    apb(1'h1, tsp_pkg::OFF_TRIG, 32'h1, rd);
    apb(1'h0, tsp_pkg::OFF_STAT, 32'h0, rd);
    chk("soft reset", rd & 32'h1fff, 32'h0);
    apb(1'h1, tsp_pkg::OFF_TRIG, 32'h0, rd);
    $display("test registers done");
    // receive eight words, send one and then underrun
    seed = lfsr(seed);
    txw = seed;
    apb(1'h1, tsp_pkg::OFF_TXD, txw, rd);
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      frame[255 - 32 * i -: 32] = seed;
    end
    apb(1'h1, tsp_pkg::OFF_TRIG, 32'h18, rd);
    apb(1'h0, tsp_pkg::OFF_STAT, 32'h0, st);
    chk("rx armed", {30'h0, st[1:0]}, 32'h1);
    fs0 = dev.fs_seen;
    fork
      dev.send_frame(frame, 2'h0);
      for (i = 0; i < 8; i++) begin
        n = 0;
        do begin
          apb(1'h0, tsp_pkg::OFF_STAT, 32'h0, st);
          n++;
        end while (st[16] !== 1'h1 && n < 1000);
        apb(1'h0, tsp_pkg::OFF_RXD, 32'h0, rd);
        chk("rx word", rd, frame[255 - 32 * i -: 32]);
      end
    join
    chk("tx word", dev.tx_word[0], txw);
    chk("tx underrun word", dev.tx_word[1], 32'h0);
    chk("fsync count", 32'(dev.fs_seen - fs0), 32'h1);
    apb(1'h0, tsp_pkg::OFF_STAT, 32'h0, st);
    chk("flags", st & 32'h001a_0000, 32'h0018_0000);
    apb(1'h1, tsp_pkg::OFF_STAT, 32'h001a_0000, rd);
    apb(1'h0, tsp_pkg::OFF_STAT, 32'h0, st);
    chk("flags cleared", st & 32'h001a_0000, 32'h0);
    $display("test frame done");
    // receiver disabled: no word taken
    apb(1'h1, tsp_pkg::OFF_TRIG, 32'h0, rd);
    n = 0;
    do begin
      apb(1'h0, tsp_pkg::OFF_STAT, 32'h0, st);
      n++;
    end while (st[1:0] !== 2'h0 && n < 100);
    chk("rx idle", {30'h0, st[1:0]}, 32'h0);
    seed = lfsr(seed);
    dev.send_frame({8{seed}}, 2'h0);
    apb(1'h0, tsp_pkg::OFF_STAT, 32'h0, st);
    chk("rx disabled", {31'h0, st[16]}, 32'h0);
    $display("test disable done");
    // inverted bit clock and frame sync at the pins
    apb(1'h1, tsp_pkg::OFF_POL, 32'h3, rd);
    apb(1'h1, tsp_pkg::OFF_TRIG, 32'h8, rd);
    seed = lfsr(seed);
    fork
      dev.send_frame({8{seed}}, 2'h3);
      begin
        n = 0;
        do begin
          apb(1'h0, tsp_pkg::OFF_STAT, 32'h0, st);
          n++;
        end while (st[16] !== 1'h1 && n < 1000);
        apb(1'h0, tsp_pkg::OFF_RXD, 32'h0, rd);
        chk("rx inverted", rd, seed);
      end
    join
    $display("test polarity done");
    test_done();
  end
endmodule : tb_top
